//--- uib_defines.svh
`ifndef UIB_DEFINES_SVH
`define UIB_DEFINES_SVH

// ----------------------------------------
// Register indices, byte address = 4 * index
// ----------------------------------------
`define UIB_IDX_EP8_FIFO_REQ 16'hE657
`define UIB_IDX_IBN_EN 16'hE658
`define UIB_IDX_IBN_REQ 16'hE659
`define UIB_IDX_NAK_EN 16'hE65A
`define UIB_IDX_NAK_REQ 16'hE65B
`define UIB_IDX_BUS_EN 16'hE65C
`define UIB_IDX_BUS_REQ 16'hE65D
`define UIB_IDX_EP_EN 16'hE65E
`define UIB_IDX_EP_REQ 16'hE65F
`define UIB_IDX_WAVE_EN 16'hE660
`define UIB_IDX_WAVE_REQ 16'hE661
`define UIB_IDX_ERR_EN 16'hE662
`define UIB_IDX_ERR_REQ 16'hE663
`define UIB_IDX_ERR_CNT_LIM 16'hE664
`define UIB_IDX_ERR_CNT_CLR 16'hE665
`define UIB_IDX_BUS_VEC 16'hE666
`define UIB_IDX_FIFO_VEC 16'hE667
`define UIB_IDX_SETUP 16'hE668
`define UIB_IDX_IRQ_STATUS 16'hE669
`define UIB_IDX_IRQ_MASK 16'hE66A

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define UIB_SETUP_BUS_AV_BIT 3
`define UIB_SETUP_SRC_BIT 1
`define UIB_SETUP_FIFO_AV_BIT 0
`define UIB_SETUP_MASK 8'h0B
`define UIB_NAK_COMBINED_BIT 0
`define UIB_LIMIT_RESET 4'h4
`define UIB_ST_BUS_BIT 0
`define UIB_ST_FIFO_BIT 1
`define UIB_ST_LIMIT_BIT 2

`endif

//--- uib_pkg.sv
package uib_pkg;

  // Event pulses from the endpoint, bus and waveform logic
  typedef struct packed {
    logic [2:0] ep8_flag;
    logic [5:0] in_bulk_nak;
    logic [5:0] ping_nak;
    logic [6:0] bus_evt;
    logic [7:0] ep_evt;
    logic [1:0] wave;
    logic [3:0] iso_err;
    logic bus_error;
  } uib_events_t;

  // Lines and vectors toward the core
  typedef struct packed {
    logic int2;
    logic int4;
    logic bus_av_en;
    logic fifo_av_en;
    logic [4:0] bus_vec;
    logic [3:0] fifo_vec;
  } uib_core_t;

endpackage

//--- uib_irq_bank.sv
`timescale 1ns/10ps
`include "uib_defines.svh"
// ----------------------------------------
// Summary of operation
// ----------------------------------------
// Summary of operation
// - A one written to a request bit clears it, a zero does nothing, and software never sets one.
// - The endpoint 8 FIFO flag request holds level, empty and full bits in 2:0, upper bits zero, reset zero.
// - IN bulk NAK enable and request bits exist for endpoints 0,1,2,4,6,8 in bits 0-5, bits 7:6 zero.
// - Ping-NAK requests for endpoints 8,6,4,2,1,0 sit in bits 7:2, and bit 0 is the combined IN bulk NAK.
// - Bus event enable and request bits occupy bits 6:0 and bit 7 reads zero.
// - Endpoint event enable and request bits cover 8,6,4,2,1out,1in,0out,0in from bit 7 down, reset zero.
// - Waveform request bit 1 marks a hook point and bit 0 marks return to idle.
// - An isochronous error on endpoint 8, 6, 4 or 2 sets request bits 7:4.
// - A 4-bit error count sits in 7:4 with a limit in 3:0 defaulting to 4, and reaching it sets request bit 0.
// - Any write with byte lane 0 to the count clear register zeroes the error count; it is write only.
// - The bus vector register shows a 5-bit source code in bits 6:2, other bits zero.
// - The FIFO vector register shows a 4-bit source code in bits 5:2, other bits zero.
// - The setup register holds bus autovector enable in bit 3, line source in bit 1, FIFO autovector in bit 0.
// - With source select 0 the second line follows its pin, with 1 it follows FIFO and waveform requests.
module uib_irq_bank (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [31:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Event sources
  input wire uib_pkg::uib_events_t events_in,
  input wire logic [2:0] ep8_fifo_flag_enable_in,
  input wire logic int4_pin_in,
  // Toward the core
  output uib_pkg::uib_core_t core_out,
  output logic irq_out
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic ack_r;
  logic [31:0] rdata_r;
  logic [15:0] idx;
  logic aligned;
  logic req_new;
  logic acc;
  logic [7:0] wdat;
  logic [7:0] rd_value;

  assign idx = wb_adr_in[17:2];
  assign aligned = (wb_adr_in[31:18] == 14'h0000) && (wb_adr_in[1:0] == 2'h0);
  assign req_new = wb_cyc_in && wb_stb_in && !ack_r;
  // Effects land on the edge where the master samples ack
  assign acc = wb_cyc_in && wb_stb_in && ack_r;
  assign wdat = wb_dat_in[7:0];

  function automatic logic wr_hit(input logic a, input logic we, input logic s0, input logic ok,
                                  input logic [15:0] i, input logic [15:0] t);
    wr_hit = a && we && s0 && ok && (i == t);
  endfunction

  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set, input logic [7:0] clr);
    // Set wins over a clear in the same cycle
    w1c = (cur & ~clr) | set;
  endfunction

  // Lowest set bit gives the source code; zero when idle
  function automatic logic [4:0] lowest(input logic [31:0] v);
    lowest = 5'h00;
    for (int k = 31; k >= 0; k--) begin
      if (v[k]) begin
        lowest = k[4:0];
      end
    end
  endfunction

  logic w_ep8, w_ibn_en, w_ibn, w_nak_en, w_nak, w_bus_en, w_bus, w_ep_en, w_ep;
  logic w_wave_en, w_wave, w_err_en, w_err, w_lim, w_clr, w_setup, w_mask;
  assign w_ep8 = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_EP8_FIFO_REQ);
  assign w_ibn_en = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_IBN_EN);
  assign w_ibn = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_IBN_REQ);
  assign w_nak_en = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_NAK_EN);
  assign w_nak = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_NAK_REQ);
  assign w_bus_en = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_BUS_EN);
  assign w_bus = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_BUS_REQ);
  assign w_ep_en = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_EP_EN);
  assign w_ep = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_EP_REQ);
  assign w_wave_en = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_WAVE_EN);
  assign w_wave = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_WAVE_REQ);
  assign w_err_en = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_ERR_EN);
  assign w_err = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_ERR_REQ);
  assign w_lim = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_ERR_CNT_LIM);
  assign w_clr = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_ERR_CNT_CLR);
  assign w_setup = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_SETUP);
  assign w_mask = wr_hit(acc, wb_we_in, wb_sel_in[0], aligned, idx, `UIB_IDX_IRQ_MASK);

  // ----------------------------------------
  // Enable registers
  // ----------------------------------------
  logic [5:0] ibn_en_r;
  logic [7:0] nak_en_r, bus_en_r, ep_en_r, err_en_r, setup_r;
  logic [1:0] wave_en_r;
  logic [3:0] limit_r;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ibn_en_r <= 6'h00;
      nak_en_r <= 8'h00;
      bus_en_r <= 8'h00;
      ep_en_r <= 8'h00;
      wave_en_r <= 2'h0;
      err_en_r <= 8'h00;
    end else begin
      if (w_ibn_en) ibn_en_r <= wdat[5:0];
      if (w_nak_en) nak_en_r <= wdat & 8'hFD;
      if (w_bus_en) bus_en_r <= wdat & 8'h7F;
      if (w_ep_en) ep_en_r <= wdat;
      if (w_wave_en) wave_en_r <= wdat[1:0];
      if (w_err_en) err_en_r <= wdat & 8'hF1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      setup_r <= 8'h00;
    end else if (w_setup) begin
      setup_r <= wdat & `UIB_SETUP_MASK;
    end
  end

  // ----------------------------------------
  // Request registers
  // ----------------------------------------
  logic [7:0] ep8_req_r, ibn_req_r, nak_req_r, bus_req_r, ep_req_r, wave_req_r, err_req_r;
  logic ibn_any;
  logic limit_hit;

  // Any enabled IN bulk NAK event feeds the combined bit
  assign ibn_any = |(events_in.in_bulk_nak & ibn_en_r);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ep8_req_r <= 8'h00;
      ibn_req_r <= 8'h00;
      nak_req_r <= 8'h00;
      bus_req_r <= 8'h00;
      ep_req_r <= 8'h00;
      wave_req_r <= 8'h00;
      err_req_r <= 8'h00;
    end else begin
      ep8_req_r <= w1c(ep8_req_r, {5'h00, events_in.ep8_flag}, w_ep8 ? wdat : 8'h00);
      ibn_req_r <= w1c(ibn_req_r, {2'h0, events_in.in_bulk_nak}, w_ibn ? wdat : 8'h00);
      nak_req_r <= w1c(nak_req_r, {events_in.ping_nak, 1'b0, ibn_any}, w_nak ? wdat : 8'h00);
      bus_req_r <= w1c(bus_req_r, {1'b0, events_in.bus_evt}, w_bus ? wdat : 8'h00);
      ep_req_r <= w1c(ep_req_r, events_in.ep_evt, w_ep ? wdat : 8'h00);
      wave_req_r <= w1c(wave_req_r, {6'h00, events_in.wave}, w_wave ? wdat : 8'h00);
      err_req_r <= w1c(err_req_r, {events_in.iso_err, 3'h0, limit_hit}, w_err ? wdat : 8'h00);
    end
  end

  // ----------------------------------------
  // Error counter
  // ----------------------------------------
  logic [3:0] err_cnt_r;
  logic [3:0] err_cnt_nxt;

  // Saturates so a long error burst cannot wrap past the limit
  assign err_cnt_nxt = (err_cnt_r == 4'hF) ? err_cnt_r : err_cnt_r + 4'h1;
  assign limit_hit = events_in.bus_error && (err_cnt_r != 4'hF) && (err_cnt_nxt == limit_r);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      err_cnt_r <= 4'h0;
    end else if (w_clr) begin
      err_cnt_r <= 4'h0;
    end else if (events_in.bus_error) begin
      err_cnt_r <= err_cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      limit_r <= `UIB_LIMIT_RESET;
    end else if (w_lim) begin
      limit_r <= wdat[3:0];
    end
  end

  // ----------------------------------------
  // Lines and vectors
  // ----------------------------------------
  logic [7:0] bus_pend, ep_pend, nak_pend, err_pend;
  logic [4:0] fifo_pend;
  logic int2_line, fifo_line;
  logic [4:0] bus_code;
  logic [3:0] fifo_code;

  assign bus_pend = bus_req_r & bus_en_r;
  assign ep_pend = ep_req_r & ep_en_r;
  assign nak_pend = nak_req_r & nak_en_r;
  assign err_pend = err_req_r & err_en_r;
  assign fifo_pend = {wave_req_r[1:0] & wave_en_r, ep8_req_r[2:0] & ep8_fifo_flag_enable_in};
  assign int2_line = |{bus_pend, ep_pend, nak_pend, err_pend};
  assign fifo_line = |fifo_pend;
  // Bus, endpoint, nak, error groups in falling priority
  assign bus_code = lowest({5'h00, err_pend[7:4], err_pend[0], nak_pend[7:2], nak_pend[0], ep_pend,
                            bus_pend[6:0]});
  assign fifo_code = 4'(lowest({27'h0000000, fifo_pend}));

  always_comb begin
    core_out.int2 = int2_line;
    core_out.int4 = setup_r[`UIB_SETUP_SRC_BIT] ? fifo_line : int4_pin_in;
    core_out.bus_av_en = setup_r[`UIB_SETUP_BUS_AV_BIT];
    core_out.fifo_av_en = setup_r[`UIB_SETUP_FIFO_AV_BIT];
    core_out.bus_vec = bus_code;
    core_out.fifo_vec = fifo_code;
  end

  // ----------------------------------------
  // Block status and mask
  // ----------------------------------------
  logic [2:0] st_r, mask_r, st_set;
  logic [2:0] st_clr_r;
  logic int2_d_r, fifo_d_r;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      int2_d_r <= 1'b0;
      fifo_d_r <= 1'b0;
    end else begin
      int2_d_r <= int2_line;
      fifo_d_r <= fifo_line;
    end
  end

  assign st_set = {limit_hit, fifo_line && !fifo_d_r, int2_line && !int2_d_r};

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_r <= 3'h0;
    end else if (acc && !wb_we_in && aligned && idx == `UIB_IDX_IRQ_STATUS) begin
      // Clear only what the read captured; later sets survive
      st_r <= (st_r & ~st_clr_r) | st_set;
    end else begin
      st_r <= st_r | st_set;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mask_r <= 3'h0;
    end else if (w_mask) begin
      mask_r <= wdat[2:0];
    end
  end

  assign irq_out = |(st_r & mask_r);

  // ----------------------------------------
  // Read mux and ack
  // ----------------------------------------
  always_comb begin
    rd_value = 8'h00;
    if (aligned) begin
      unique case (idx)
        `UIB_IDX_EP8_FIFO_REQ: rd_value = ep8_req_r;
        `UIB_IDX_IBN_EN: rd_value = {2'h0, ibn_en_r};
        `UIB_IDX_IBN_REQ: rd_value = ibn_req_r;
        `UIB_IDX_NAK_EN: rd_value = nak_en_r;
        `UIB_IDX_NAK_REQ: rd_value = nak_req_r;
        `UIB_IDX_BUS_EN: rd_value = bus_en_r;
        `UIB_IDX_BUS_REQ: rd_value = bus_req_r;
        `UIB_IDX_EP_EN: rd_value = ep_en_r;
        `UIB_IDX_EP_REQ: rd_value = ep_req_r;
        `UIB_IDX_WAVE_EN: rd_value = {6'h00, wave_en_r};
        `UIB_IDX_WAVE_REQ: rd_value = wave_req_r;
        `UIB_IDX_ERR_EN: rd_value = err_en_r;
        `UIB_IDX_ERR_REQ: rd_value = err_req_r;
        `UIB_IDX_ERR_CNT_LIM: rd_value = {err_cnt_r, limit_r};
        `UIB_IDX_BUS_VEC: rd_value = {1'b0, bus_code, 2'h0};
        `UIB_IDX_FIFO_VEC: rd_value = {2'h0, fifo_code, 2'h0};
        `UIB_IDX_SETUP: rd_value = setup_r;
        `UIB_IDX_IRQ_STATUS: rd_value = {5'h00, st_r};
        `UIB_IDX_IRQ_MASK: rd_value = {5'h00, mask_r};
        default: rd_value = 8'h00; // clear register and unmapped read zero
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
      st_clr_r <= 3'h0;
    end else begin
      ack_r <= req_new;
      if (req_new) begin
        rdata_r <= {24'h000000, rd_value};
        st_clr_r <= st_r;
      end
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = rdata_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence seq_req;
    wb_cyc_in && wb_stb_in && !ack_r;
  endsequence

  sequence seq_ack;
    ack_r ##1 !ack_r;
  endsequence

  chk_bus_answer: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    seq_req |=> seq_ack) else $error("bus answer not a one-cycle ack");

  chk_w1c_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (w_bus && wdat[0] && !events_in.bus_evt[0]) |=> !bus_req_r[0]) else $error("request not cleared");

  chk_no_sw_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (w_ep && events_in.ep_evt == 8'h00) |=> ((ep_req_r & ~$past(ep_req_r)) == 8'h00))
    else $error("write set a request bit");

  chk_ep8_upper: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (req_new && aligned && idx == `UIB_IDX_EP8_FIFO_REQ) |=> (ack_r && wb_dat_out[7:3] == 5'h00))
    else $error("fifo flag upper bits not zero");

  chk_ibn_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    events_in.in_bulk_nak[5] |=> ibn_req_r[5] && !ibn_req_r[7]) else $error("bulk nak not recorded");

  chk_ping_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (events_in.in_bulk_nak[0] && ibn_en_r[0]) |=> nak_req_r[`UIB_NAK_COMBINED_BIT] && !nak_req_r[1])
    else $error("combined nak not set");

  chk_err_limit: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (events_in.bus_error && !w_clr && err_cnt_r != 4'hF && err_cnt_r + 4'h1 == limit_r)
    |=> (err_req_r[0] && err_cnt_r == $past(limit_r))) else $error("limit request missing");

  chk_count_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    w_clr |=> err_cnt_r == 4'h0) else $error("error count not cleared");

  chk_line_source: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    core_out.int4 == (setup_r[1] ? fifo_line : int4_pin_in)) else $error("second line source wrong");

  chk_line_drop: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (int2_line && w_bus && wdat == 8'hFF && events_in == '0 && ep_pend == 8'h00 && nak_pend == 8'h00
     && err_pend == 8'h00 && !ibn_any) |=> !core_out.int2) else $error("line stays after clear");

  chk_src_fifo: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (setup_r[`UIB_SETUP_SRC_BIT] && events_in.wave[0] && wave_en_r[0]) |=> core_out.int4)
    else $error("second line misses fifo source");

  chk_vec_idle: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ({bus_pend, ep_pend, nak_pend, err_pend} == 32'h00000000) |-> core_out.bus_vec == 5'h00)
    else $error("bus vector not zero when idle");

  chk_vec_hook: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (fifo_pend == 5'h10) |-> core_out.fifo_vec == 4'h4)
    else $error("hook vector wrong");

  chk_bus_top_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (req_new && aligned && idx == `UIB_IDX_BUS_REQ) |=> (ack_r && wb_dat_out[7] == 1'b0))
    else $error("bus request bit 7 not zero");

endmodule

//--- uib_core_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Core side: counts bus line entries, keeps the vector seen at entry
// ----------------------------------------
module uib_core_model (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // From the bank
  input wire uib_pkg::uib_core_t core_in,
  input wire logic irq_in,
  // Observations
  output logic [7:0] entries_out,
  output logic [4:0] last_vec_out,
  output logic [7:0] irq_rises_out
);
  logic int2_prev_r;
  logic irq_prev_r;

  // Entry taken one cycle after the line rises, as a core would
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      int2_prev_r <= 1'b0;
      entries_out <= 8'h00;
      last_vec_out <= 5'h00;
      irq_prev_r <= 1'b0;
      irq_rises_out <= 8'h00;
    end else begin
      int2_prev_r <= core_in.int2;
      irq_prev_r <= irq_in;
      if (irq_in && !irq_prev_r) begin
        irq_rises_out <= irq_rises_out + 8'h01;
      end
      if (core_in.int2 && !int2_prev_r) begin
        entries_out <= entries_out + 8'h01;
        last_vec_out <= core_in.bus_vec;
      end
    end
  end
endmodule

//--- uib_irq_bank_tb.sv
`timescale 1ns/10ps
`include "uib_defines.svh"
module uib_irq_bank_tb;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] wb_dat_out;
  logic wb_ack_out;
  uib_pkg::uib_events_t ev = '0;
  uib_pkg::uib_events_t e;
  logic [2:0] fl_en = 3'h7;
  logic pin = 1'b0;
  uib_pkg::uib_core_t core_out;
  logic irq_out;
  logic [7:0] entries;
  logic [4:0] last_vec;
  logic [7:0] irq_rises;
  logic [7:0] rd;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [15:0] en_idx [7] = '{`UIB_IDX_IBN_EN, `UIB_IDX_NAK_EN, `UIB_IDX_BUS_EN, `UIB_IDX_EP_EN,
    `UIB_IDX_WAVE_EN, `UIB_IDX_ERR_EN, `UIB_IDX_SETUP};
  logic [7:0] en_exp [7] = '{8'h3F, 8'hFD, 8'h7F, 8'hFF, 8'h03, 8'hF1, 8'h0B};
  // Bus group last, so its clear is the one that drops the line
  logic [15:0] rq_idx [7] = '{`UIB_IDX_EP8_FIFO_REQ, `UIB_IDX_IBN_REQ, `UIB_IDX_NAK_REQ, `UIB_IDX_EP_REQ,
    `UIB_IDX_WAVE_REQ, `UIB_IDX_ERR_REQ, `UIB_IDX_BUS_REQ};
  logic [7:0] rq_exp [7] = '{8'h07, 8'h3F, 8'hFD, 8'hFF, 8'h03, 8'hF0, 8'h7F};

  always #10 clk_sys_in = ~clk_sys_in;

  uib_irq_bank dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .events_in(ev), .ep8_fifo_flag_enable_in(fl_en), .int4_pin_in(pin),
    .core_out(core_out), .irq_out(irq_out));

  uib_core_model core_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .core_in(core_out), .irq_in(irq_out),
    .entries_out(entries), .last_vec_out(last_vec), .irq_rises_out(irq_rises));

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // Classic Wishbone single cycle
  // ----------------------------------------
  task xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_sys_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {14'h0, idx, 2'b00};
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    rd = wb_dat_out[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  task wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  task rchk(input logic [15:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask

  // One-cycle event pulse, then one settling cycle
  task pulse(input uib_pkg::uib_events_t p);
    @(posedge clk_sys_in);
    ev <= p;
    @(posedge clk_sys_in);
    ev <= '0;
    @(posedge clk_sys_in);
  endtask

  task errs(input int k);
    e = '0;
    e.bus_error = 1'b1;
    repeat (k) pulse(e);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    // Reset values
    rchk(`UIB_IDX_EP8_FIFO_REQ, 8'h00);
    rchk(`UIB_IDX_EP_EN, 8'h00);
    rchk(`UIB_IDX_EP_REQ, 8'h00);
    rchk(`UIB_IDX_ERR_CNT_LIM, 8'h04);
    rchk(`UIB_IDX_SETUP, 8'h00);
    rchk(`UIB_IDX_BUS_VEC, 8'h00);
    // Enables keep only their defined bits
    for (int i = 0; i < 7; i++) begin
      wr(en_idx[i], 8'hFF);
      rchk(en_idx[i], en_exp[i]);
    end
    // A write without its low byte lane is ignored
    sel <= 4'hE;
    wr(`UIB_IDX_EP_EN, 8'h00);
    sel <= 4'hF;
    rchk(`UIB_IDX_EP_EN, 8'hFF);
    chk({6'h0, core_out.bus_av_en, core_out.fifo_av_en}, 8'h03);
    // Every source at once; the error count is left to its own scenario
    e = '1;
    e.bus_error = 1'b0;
    pulse(e);
    chk({7'h0, core_out.int2}, 8'h01);
    chk({7'h0, core_out.int4}, 8'h01);
    for (int i = 0; i < 7; i++) begin
      rchk(rq_idx[i], rq_exp[i]);
      wr(rq_idx[i], 8'h00);
      rchk(rq_idx[i], rq_exp[i]);
      wr(rq_idx[i], 8'hFF);
      rchk(rq_idx[i], 8'h00);
    end
    chk({7'h0, core_out.int2}, 8'h00);
    chk({7'h0, core_out.int4}, 8'h00);
    // Second line back on its pin
    wr(`UIB_IDX_SETUP, 8'h00);
    pin <= 1'b1;
    @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    chk({7'h0, core_out.int4}, 8'h01);
    pin <= 1'b0;
    @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    chk({7'h0, core_out.int4}, 8'h00);
    // Vectors pick the lowest pending source
    e = '0;
    e.bus_evt[3] = 1'b1;
    e.ep_evt[0] = 1'b1;
    e.ep8_flag[1] = 1'b1;
    e.wave[1] = 1'b1;
    pulse(e);
    rchk(`UIB_IDX_BUS_VEC, 8'h0C);
    chk({3'h0, core_out.bus_vec}, 8'h03);
    chk({3'h0, last_vec}, 8'h03);
    rchk(`UIB_IDX_FIFO_VEC, 8'h04);
    wr(`UIB_IDX_BUS_REQ, 8'h08);
    rchk(`UIB_IDX_BUS_VEC, 8'h1C);
    wr(`UIB_IDX_EP8_FIFO_REQ, 8'h02);
    rchk(`UIB_IDX_FIFO_VEC, 8'h10);
    wr(`UIB_IDX_EP_REQ, 8'hFF);
    wr(`UIB_IDX_WAVE_REQ, 8'hFF);
    rchk(`UIB_IDX_BUS_VEC, 8'h00);
    // Error count against the default limit, then against a limit of 2
    errs(3);
    rchk(`UIB_IDX_ERR_CNT_LIM, 8'h34);
    rchk(`UIB_IDX_ERR_REQ, 8'h00);
    errs(1);
    rchk(`UIB_IDX_ERR_CNT_LIM, 8'h44);
    rchk(`UIB_IDX_ERR_REQ, 8'h01);
    wr(`UIB_IDX_ERR_CNT_CLR, 8'h5A);
    rchk(`UIB_IDX_ERR_CNT_LIM, 8'h04);
    rchk(`UIB_IDX_ERR_CNT_CLR, 8'h00);
    wr(`UIB_IDX_ERR_REQ, 8'h01);
    wr(`UIB_IDX_ERR_CNT_LIM, 8'hF2);
    rchk(`UIB_IDX_ERR_CNT_LIM, 8'h02);
    errs(2);
    rchk(`UIB_IDX_ERR_CNT_LIM, 8'h22);
    rchk(`UIB_IDX_ERR_REQ, 8'h01);
    // Status, mask and the level line
    wr(`UIB_IDX_IRQ_MASK, 8'hFF);
    rchk(`UIB_IDX_IRQ_MASK, 8'h07);
    chk({7'h0, irq_out}, 8'h01);
    xfer(1'b0, `UIB_IDX_IRQ_STATUS, 8'h00);
    chk(rd & 8'h04, 8'h04);
    rchk(`UIB_IDX_IRQ_STATUS, 8'h00);
    chk({7'h0, irq_out}, 8'h00);
    // Unmapped place reads zero and ignores writes
    wr(16'hE670, 8'hA5);
    rchk(16'hE670, 8'h00);
    chk(entries, 8'h04);
    chk(irq_rises, 8'h01);
    report_and_stop();
  end
endmodule
